// File: mcuid_pkg.sv
// mcuid_pkg: constants, types and encodings for the instruction decoder.
// assumes one 125 MHz core clock and a four-phase instruction cycle.
package mcuid_pkg;

	// four clock phases make one instruction cycle
	localparam int unsigned PHASES    = 4;
	localparam logic [1:0]  PH_LAST   = 2'h3;

	// register port map (word offsets)
	localparam logic [1:0]  REG_STATUS = 2'h0;
	localparam logic [1:0]  REG_BANK   = 2'h1;
	localparam logic [1:0]  REG_CTRL   = 2'h2;
	localparam logic [1:0]  REG_WORD   = 2'h3;

	// reset values
	localparam logic [7:0]  BANK_RST   = 8'h00;
	localparam logic        RUN_RST    = 1'b1;
	localparam logic        TO_RST     = 1'b1;
	localparam logic        PD_RST     = 1'b1;

	// access bank split and special file addresses (access bank offsets)
	localparam logic [7:0]  ACCESS_SPLIT = 8'h80;
	localparam logic [3:0]  ACCESS_HI_BANK = 4'hF;
	localparam logic [7:0]  PORT_FIRST = 8'h80;
	localparam logic [7:0]  PORT_LAST  = 8'h84;
	localparam logic [7:0]  TIMER_ZERO_ADDR = 8'hD6;

	// second-word prefix of two-word instructions
	localparam logic [3:0]  WORD2_PREFIX = 4'hF;

	// flag update mask bits {c, dc, z, ov, n}
	localparam logic [4:0]  FM_ALL  = 5'h1F;
	localparam logic [4:0]  FM_ZN   = 5'h05;
	localparam logic [4:0]  FM_CZN  = 5'h15;
	localparam logic [4:0]  FM_Z    = 5'h04;
	localparam logic [4:0]  FM_C    = 5'h10;
	localparam logic [4:0]  FM_NONE = 5'h00;

	typedef enum logic [4:0] {
		OP_NOP, OP_BYTE, OP_BIT, OP_LIT, OP_BRA_COND, OP_BRA_REL,
		OP_CALL_REL, OP_GOTO, OP_CALL, OP_MOVE_FF, OP_RETURN, OP_INTERRUPT_RETURN,
		OP_LITERAL_RETURN, OP_TBL_RD, OP_TBL_WR, OP_SLEEP, OP_CLRWDT, OP_BANKLIT,
		OP_MULLIT, OP_RESET, OP_PUSH, OP_POP, OP_DAW, OP_LFSR
	} mcuid_op_t;

	// gray codes along exec -> word2 -> flush -> table write hold
	typedef enum logic [1:0] {
		ST_EXEC  = 2'b00,
		ST_WORD2 = 2'b01,
		ST_FLUSH = 2'b11,
		ST_TBLW  = 2'b10
	} mcuid_state_t;

	typedef struct packed {
		logic c;
		logic dc;
		logic z;
		logic ov;
		logic n;
	} mcuid_flags_t;

	typedef struct packed {
		mcuid_op_t   op;
		logic [7:0]  alu_opcode;
		logic        dest_file;
		logic [11:0] file_addr;
		logic [11:0] dst_addr;
		logic [2:0]  bit_pos;
		logic [7:0]  literal;
		logic [19:0] target;
		logic [10:0] rel_offset;
		logic        branch_taken;
		logic        skip_test;
		logic        fast;
		logic [1:0]  tbl_mode;
		logic [4:0]  flag_mask;
		logic        use_pins;
		logic        clr_prescaler;
		logic        working_register_load;
		logic        irq_enable_set;
	} mcuid_ctrl_t;

endpackage

// File: mcuid_cond.sv
// mcuid_cond: branch condition test and status flag update mask.
// purely combinational; inputs come from the same clock domain.
`timescale 1ns/10ps
module mcuid_cond
	import mcuid_pkg::*;
(
	input  wire logic [15:0]  word_i,
	input  wire mcuid_flags_t flags_i,
	output logic              cond_true_o,
	output logic [4:0]        flag_mask_o
);

	// condition select: z, nz, c, nc, ov, nov, n, nn
	always_comb begin
		unique case (word_i[10:8])
			3'h0: cond_true_o = flags_i.z;
			3'h1: cond_true_o = !flags_i.z;
			3'h2: cond_true_o = flags_i.c;
			3'h3: cond_true_o = !flags_i.c;
			3'h4: cond_true_o = flags_i.ov;
			3'h5: cond_true_o = !flags_i.ov;
			3'h6: cond_true_o = flags_i.n;
			3'h7: cond_true_o = !flags_i.n;
		endcase
	end

	// which flags an instruction may update
	always_comb begin
		flag_mask_o = FM_NONE;
		casez (word_i[15:8])
			8'b0010_00??: flag_mask_o = FM_ALL;
			8'b0101_10??: flag_mask_o = FM_ALL;
			8'b0010_01??, 8'b0000_01??, 8'b0010_10??, 8'b0110_110?,
			8'b0101_01??, 8'b0101_11??, 8'h0F, 8'h08:
				flag_mask_o = FM_ALL;
			8'b0001_01??, 8'b0001_11??, 8'b0001_00??, 8'b0101_00??,
			8'b0100_01??, 8'b0100_00??, 8'b0001_10??, 8'h0B, 8'h09,
			8'h0A:
				flag_mask_o = FM_ZN;
			8'b0011_01??, 8'b0011_00??:
				flag_mask_o = FM_CZN;
			8'b0110_101?:
				flag_mask_o = FM_Z;
			8'h0D: flag_mask_o = FM_NONE;
			8'h00: flag_mask_o = (word_i[7:0] == 8'h07) ? FM_C : FM_NONE;
			default: flag_mask_o = FM_NONE;
		endcase
	end

endmodule

// File: mcuid_decoder.sv
// mcuid_decoder: instruction decoder of an 8-bit core with 16-bit words.
// assumes program memory holds the next word stable on word_i until
// word_take_o, and the alu reports skip tests in the executing cycle.
//
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/10ps

// Function
// - byte ops: d=0 writes working register, d=1 writes the file.
// - a=0 forces access bank, a=1 lets bank select choose.
// - byte and bit ops carry 8-bit file address in low byte.
// - file move: 12-bit source, second word 1111 plus 12-bit dest.
// - bit ops select the bit by a 3-bit position field.
// - literal ops take an 8-bit immediate from the low byte.
// - goto/call: 20-bit target split over two words, call fast bit.
// - conditional branch 1110 0ccc, 8-bit signed offset, eight tests.
// - taken test or program counter change adds one nop cycle.
// - lone second word with 1111 prefix executes as nop.
// - read-modify-write of a port uses pin levels, not latch; use_pins is set only for a=0 access, not a=1 with bank F.
// - writing timer zero count clears its prescaler if assigned; clr_prescaler is set only for byte and bit ops with a=0, not file moves.
// - started table write holds until the memory write ends.
// - standby 0x0003, one cycle, updates timeout and powerdown flags.
// - interrupt return 0x001s, two cycles, re-enables interrupts.
// - literal return 0x0C kk loads working register, two cycles.
// - table reads two cycles, low nibbles 8..B pick pointer mode.
// - table writes low nibbles C..F pick pointer mode, at least two cycles, more while the memory write is busy.
// - table ops use 21-bit pointer and 8-bit latch.
// - bank literal load sets low four bank bits, no flags.
// - add with carry 0010 00da updates all five flags.
// - subtract with borrow 0101 10da updates all five flags.
// - fast bit moves registers through shadows; zero means none.
// - one instruction cycle is four clock phases.
module mcuid_decoder
	import mcuid_pkg::*;
(
	input  wire logic         mclk_i,
	input  wire logic         resetn_i,
	input  wire logic [15:0]  word_i,
	input  wire mcuid_flags_t flags_i,
	input  wire logic         skip_true_i,
	input  wire logic         prescaler_assigned_i,
	input  wire logic         tbl_write_busy_i,
	input  wire logic [1:0]   reg_addr_i,
	input  wire logic [15:0]  reg_wdata_i,
	input  wire logic         reg_wr_i,
	input  wire logic         reg_rd_i,
	output logic [15:0]       reg_rdata_o,
	output mcuid_ctrl_t       ctrl_o,
	output logic [1:0]        phase_o,
	output logic              word_take_o,
	output logic [7:0]        bank_select_reg_o,
	output logic              timeout_flag_o,
	output logic              powerdown_flag_o,
	output logic              tbl_ptr_step_o,
	output logic              tbl_write_active_o
);

	typedef struct packed {
		logic [1:0]   ph;
		mcuid_state_t st;
		mcuid_ctrl_t  ctrl;
		logic [15:0]  word1;
		logic [15:0]  last_word;
		logic [7:0]   bank;
		logic         run;
		logic         to;
		logic         pd;
		logic         take;
		logic         tbl_step;
		logic         tbl_active;
		logic [15:0]  rdata;
	} mcuid_regs_t;

	mcuid_regs_t s_q;
	mcuid_regs_t s_d;

	logic       cond_true;
	logic [4:0] flag_mask;

	mcuid_cond u_cond (
		.word_i      (word_i),
		.flags_i     (flags_i),
		.cond_true_o (cond_true),
		.flag_mask_o (flag_mask)
	);

	// full data address from access bit, file byte and bank register
	function automatic logic [11:0] data_addr(input logic a,
		input logic [7:0] f, input logic [7:0] bank);
		logic [3:0] b;
		b = (f < ACCESS_SPLIT) ? 4'h0 : ACCESS_HI_BANK;
		if (a) begin
			b = bank[3:0];
		end
		return {b, f};
	endfunction

	function automatic logic is_port(input logic a, input logic [7:0] f);
		return !a && (f >= PORT_FIRST) && (f <= PORT_LAST);
	endfunction

	function automatic logic is_timer(input logic a, input logic [7:0] f);
		return !a && (f == TIMER_ZERO_ADDR);
	endfunction

	function automatic mcuid_ctrl_t nop_ctrl();
		mcuid_ctrl_t c;
		c = '0;
		c.op = OP_NOP;
		return c;
	endfunction

	mcuid_ctrl_t dec;
	mcuid_state_t dec_next;
	logic dec_two_word;

	// single-word decode of the word on word_i
	always_comb begin
		dec = nop_ctrl();
		dec_next = ST_EXEC;
		dec_two_word = 1'b0;
		dec.alu_opcode = word_i[15:8];
		dec.flag_mask = flag_mask;
		dec.literal = word_i[7:0];
		casez (word_i)
			16'h0003: dec.op = OP_SLEEP;
			16'h0004: dec.op = OP_CLRWDT;
			16'h0005: dec.op = OP_PUSH;
			16'h0006: dec.op = OP_POP;
			16'h0007: dec.op = OP_DAW;
			16'b0000_0000_0000_1???: begin
				// bit 2 picks write, bits 1:0 the pointer mode
				dec.op = word_i[2] ? OP_TBL_WR : OP_TBL_RD;
				dec.tbl_mode = word_i[1:0];
				dec_next = word_i[2] ? ST_TBLW : ST_FLUSH;
			end
			16'b0000_0000_0001_000?: begin
				dec.op = OP_INTERRUPT_RETURN;
				dec.fast = word_i[0];
				dec.irq_enable_set = 1'b1;
				dec_next = ST_FLUSH;
			end
			16'b0000_0000_0001_001?: begin
				dec.op = OP_RETURN;
				dec.fast = word_i[0];
				dec_next = ST_FLUSH;
			end
			16'h00FF: dec.op = OP_RESET;
			16'b0000_0001_0000_????: begin
				dec.op = OP_BANKLIT;
				dec.flag_mask = FM_NONE;
			end
			16'b0000_1100_????_????: begin
				dec.op = OP_LITERAL_RETURN;
				dec.working_register_load = 1'b1;
				dec_next = ST_FLUSH;
			end
			16'b0000_1101_????_????: dec.op = OP_MULLIT;
			16'b0000_1???_????_????: begin
				// 0x0C and 0x0D are caught above; the rest are plain literals
				dec.op = OP_LIT;
			end
			16'b0000_001?_????_????, 16'b0000_01??_????_????,
			16'b0001_????_????_????, 16'b0010_????_????_????,
			16'b0011_????_????_????, 16'b0100_????_????_????,
			16'b0101_????_????_????, 16'b0110_????_????_????: begin
				dec.op = OP_BYTE;
				dec.file_addr = data_addr(word_i[8], word_i[7:0],
					s_q.bank);
				if (word_i[15:12] == 4'h6) begin
					dec.dest_file = word_i[11];
				end else if (word_i[15:9] == 7'b0000_001) begin
					dec.dest_file = 1'b0;
				end else begin
					dec.dest_file = word_i[9];
				end
				dec.skip_test = (word_i[15:11] == 5'b01100) ||
					(word_i[15:10] == 6'b001011) ||
					(word_i[15:10] == 6'b001111) ||
					(word_i[15:11] == 5'b01001);
			end
			16'b0111_????_????_????, 16'b1000_????_????_????,
			16'b1001_????_????_????, 16'b1010_????_????_????,
			16'b1011_????_????_????: begin
				dec.op = OP_BIT;
				dec.bit_pos = word_i[11:9];
				dec.file_addr = data_addr(word_i[8], word_i[7:0],
					s_q.bank);
				dec.skip_test = (word_i[15:13] == 3'b101);
				dec.dest_file = !dec.skip_test;
			end
			16'b1100_????_????_????,
			16'b1110_110?_????_????,
			16'b1110_1110_00??_????,
			16'b1110_1111_????_????: begin
				// first of two words; nothing executes until the second
				dec_two_word = 1'b1;
				dec_next = ST_WORD2;
			end
			16'b1101_????_????_????: begin
				dec.op = word_i[11] ? OP_CALL_REL : OP_BRA_REL;
				dec.rel_offset = word_i[10:0];
				dec.branch_taken = 1'b1;
				dec_next = ST_FLUSH;
			end
			16'b1110_0???_????_????: begin
				dec.op = OP_BRA_COND;
				dec.rel_offset = {{3{word_i[7]}}, word_i[7:0]};
				dec.branch_taken = cond_true;
				dec_next = cond_true ? ST_FLUSH : ST_EXEC;
			end
			16'b1111_????_????_????: dec.op = OP_NOP;
			default: dec.op = OP_NOP;
		endcase
		// port read-modify-write and timer zero writes
		if ((dec.op == OP_BYTE || dec.op == OP_BIT) && dec.dest_file) begin
			dec.use_pins = is_port(word_i[8], word_i[7:0]);
			dec.clr_prescaler = prescaler_assigned_i &&
				is_timer(word_i[8], word_i[7:0]);
		end
	end

	// completion of a two-word instruction from the held first word
	function automatic mcuid_ctrl_t join_words(input logic [15:0] w1,
		input logic [15:0] w2);
		mcuid_ctrl_t c;
		c = nop_ctrl();
		c.alu_opcode = w1[15:8];
		if (w2[15:12] == WORD2_PREFIX) begin
			if (w1[15:12] == 4'hC) begin
				c.op = OP_MOVE_FF;
				c.file_addr = w1[11:0];
				c.dst_addr = w2[11:0];
			end else if (w1[11:8] == 4'hF) begin
				c.op = OP_GOTO;
				c.target = {w2[11:0], w1[7:0]};
				c.branch_taken = 1'b1;
			end else if (w1[11:9] == 3'b110) begin
				c.op = OP_CALL;
				c.target = {w2[11:0], w1[7:0]};
				c.fast = w1[8];
				c.branch_taken = 1'b1;
			end else begin
				c.op = OP_LFSR;
				c.file_addr = {10'h000, w1[5:4]};
				c.target = {8'h00, w1[3:0], w2[7:0]};
			end
		end
		return c;
	endfunction

	// one register image; the instruction boundary is the last phase
	always_comb begin
		s_d = s_q;
		s_d.ph = s_q.ph + 2'h1;
		s_d.take = 1'b0;
		s_d.tbl_step = 1'b0;
		s_d.rdata = 16'h0000;
		if (reg_wr_i) begin
			if (reg_addr_i == REG_BANK) begin
				s_d.bank = {4'h0, reg_wdata_i[3:0]};
			end
			if (reg_addr_i == REG_CTRL) begin
				s_d.run = reg_wdata_i[0];
			end
		end
		if (s_q.ph == PH_LAST) begin
			s_d.ctrl = nop_ctrl();
			unique case (s_q.st)
				ST_EXEC: begin
					if (s_q.ctrl.skip_test && skip_true_i) begin
						// skipped word is dropped as the one nop cycle
						s_d.st = ST_EXEC;
						s_d.take = 1'b1;
					end else if (s_q.run) begin
						s_d.take = 1'b1;
						s_d.last_word = word_i;
						s_d.st = dec_next;
						if (dec_two_word) begin
							s_d.word1 = word_i;
						end else begin
							s_d.ctrl = dec;
						end
						if (dec.op == OP_BANKLIT) begin
							s_d.bank = {4'h0, word_i[3:0]};
						end
						if (dec.op == OP_SLEEP) begin
							s_d.to = 1'b1;
							s_d.pd = 1'b0;
						end
						if (dec.op == OP_CLRWDT) begin
							s_d.to = 1'b1;
							s_d.pd = 1'b1;
						end
						if (dec.op == OP_TBL_RD || dec.op == OP_TBL_WR) begin
							s_d.tbl_step = 1'b1;
							s_d.tbl_active = (dec.op == OP_TBL_WR);
						end
					end
				end
				ST_WORD2: begin
					s_d.take = 1'b1;
					s_d.last_word = word_i;
					s_d.ctrl = join_words(s_q.word1, word_i);
					s_d.st = ST_EXEC;
				end
				ST_FLUSH: begin
					s_d.st = ST_EXEC;
				end
				ST_TBLW: begin
					// memory write keeps the core stalled until it ends
					if (!tbl_write_busy_i) begin
						s_d.st = ST_EXEC;
						s_d.tbl_active = 1'b0;
					end
				end
			endcase
		end
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				REG_STATUS: s_d.rdata = {11'h000, s_q.tbl_active, s_q.pd,
					s_q.to, s_q.st};
				REG_BANK:   s_d.rdata = {8'h00, s_q.bank};
				REG_CTRL:   s_d.rdata = {15'h0000, s_q.run};
				REG_WORD:   s_d.rdata = s_q.last_word;
			endcase
		end
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s_q <= '0;
			s_q.ctrl.op <= OP_NOP;
			s_q.st <= ST_EXEC;
			s_q.bank <= BANK_RST;
			s_q.run <= RUN_RST;
			s_q.to <= TO_RST;
			s_q.pd <= PD_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign reg_rdata_o        = s_q.rdata;
	assign ctrl_o             = s_q.ctrl;
	assign phase_o            = s_q.ph;
	assign word_take_o        = s_q.take;
	assign bank_select_reg_o  = s_q.bank;
	assign timeout_flag_o     = s_q.to;
	assign powerdown_flag_o   = s_q.pd;
	assign tbl_ptr_step_o     = s_q.tbl_step;
	assign tbl_write_active_o = s_q.tbl_active;

endmodule

// File: mcuid_sva.sv
// mcuid_sva: port-level checks of the instruction decoder.
// assumes one clock domain; attached by the bind at the foot.
`timescale 1ns/10ps
module mcuid_sva
	import mcuid_pkg::*;
(
	input wire logic        mclk_i,
	input wire logic        resetn_i,
	input wire logic [1:0]  reg_addr_i,
	input wire logic        reg_rd_i,
	input wire logic [15:0] reg_rdata_o,
	input wire mcuid_ctrl_t ctrl_o,
	input wire logic [1:0]  phase_o,
	input wire logic        word_take_o,
	input wire logic [7:0]  bank_select_reg_o,
	input wire logic        timeout_flag_o,
	input wire logic        powerdown_flag_o,
	input wire logic        tbl_ptr_step_o
);
	logic [3:0] lit_q;

	default clocking @(posedge mclk_i); endclocking
	default disable iff (!resetn_i);

	// literal nibble as it stood in the last phase of the cycle
	always_ff @(posedge mclk_i)
		lit_q <= ctrl_o.literal[3:0];

	a_phase_wrap: assert property (
		phase_o == PH_LAST |=> phase_o == 2'h0)
		else $error("phase did not wrap to zero");
	a_ctrl_hold: assert property (
		phase_o != PH_LAST |=> $stable(ctrl_o))
		else $error("controls changed inside a cycle");
	a_take_pulse: assert property (
		word_take_o |-> phase_o == 2'h0 ##1 !word_take_o)
		else $error("take pulse misplaced");
	a_rdata_idle: assert property (
		!reg_rd_i |=> reg_rdata_o == 16'h0000)
		else $error("read data without a read");
	a_bank_read: assert property (
		reg_rd_i && reg_addr_i == REG_BANK |=>
		reg_rdata_o == {8'h00, $past(bank_select_reg_o)})
		else $error("bank read wrong");
	a_bank_width: assert property (
		bank_select_reg_o[7:4] == 4'h0)
		else $error("bank upper bits set");
	a_bank_lit: assert property (
		phase_o == PH_LAST && ctrl_o.op == OP_BANKLIT |=>
		bank_select_reg_o == {4'h0, lit_q})
		else $error("bank literal not loaded");
	// two-word jumps spend their spare cycle on the first word
	a_extra_nop: assert property (
		phase_o == PH_LAST && (ctrl_o.op == OP_LITERAL_RETURN ||
		(ctrl_o.branch_taken && ctrl_o.op != OP_GOTO &&
		ctrl_o.op != OP_CALL)) |=> ctrl_o.op == OP_NOP && !word_take_o)
		else $error("missing nop cycle");
	a_interrupt_return_nop: assert property (
		phase_o == PH_LAST && ctrl_o.op == OP_INTERRUPT_RETURN |=>
		ctrl_o.op == OP_NOP && !word_take_o)
		else $error("interrupt return not two cycles");
	a_sleep_flag: assert property (
		phase_o == PH_LAST && ctrl_o.op == OP_SLEEP |=>
		timeout_flag_o && !powerdown_flag_o)
		else $error("standby flags wrong");
	a_tbl_step: assert property (
		tbl_ptr_step_o |-> phase_o == 2'h0 &&
		(ctrl_o.op == OP_TBL_RD || ctrl_o.op == OP_TBL_WR))
		else $error("pointer step outside table op");
endmodule

bind mcuid_decoder mcuid_sva mcuid_sva_i (
	.mclk_i(mclk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
	.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .ctrl_o(ctrl_o),
	.phase_o(phase_o), .word_take_o(word_take_o),
	.bank_select_reg_o(bank_select_reg_o),
	.timeout_flag_o(timeout_flag_o), .powerdown_flag_o(powerdown_flag_o),
	.tbl_ptr_step_o(tbl_ptr_step_o));

// File: mcuid_pmem.sv
// mcuid_pmem: program memory model feeding instruction words.
// assumes the bench fills mem while reset is held low.
`timescale 1ns/10ps
module mcuid_pmem (
	input  wire logic        mclk_i,
	input  wire logic        resetn_i,
	input  wire logic        take_i,
	output logic      [15:0] word_o
);
	logic [15:0] mem [16];
	logic [3:0]  idx_q;

	// word holds until the decoder reports it consumed
	assign word_o = mem[idx_q];

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i)
			idx_q <= 4'h0;
		else if (take_i)
			idx_q <= idx_q + 4'h1;
	end
endmodule

// File: mcuid_tb.sv
// testbench: self-checking bench for the instruction decoder.
// assumes mcuid_pmem as program memory and the bound checker.
`timescale 1ns/10ps
module testbench;
	import mcuid_pkg::*;
	logic         mclk_i;
	logic         resetn_i;
	mcuid_flags_t flags;
	logic         skip;
	logic         presc;
	logic         busy;
	logic [1:0]   addr;
	logic [15:0]  wdata;
	logic         wr_s;
	logic         rd_s;
	logic [15:0]  rdata;
	mcuid_ctrl_t  ctrl;
	logic [1:0]   phase;
	logic         take;
	logic [7:0]   bank;
	logic         to_f;
	logic         pd_f;
	logic         step;
	logic         tbl_act;
	logic [15:0]  word;
	int           error_cnt;
	int           checks_done;
	int           cycles;

	mcuid_decoder mcuid_decoder_i (.mclk_i(mclk_i), .resetn_i(resetn_i),
		.word_i(word), .flags_i(flags), .skip_true_i(skip),
		.prescaler_assigned_i(presc), .tbl_write_busy_i(busy),
		.reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr_s),
		.reg_rd_i(rd_s), .reg_rdata_o(rdata), .ctrl_o(ctrl),
		.phase_o(phase), .word_take_o(take), .bank_select_reg_o(bank),
		.timeout_flag_o(to_f), .powerdown_flag_o(pd_f),
		.tbl_ptr_step_o(step), .tbl_write_active_o(tbl_act));
	mcuid_pmem mcuid_pmem_i (.mclk_i(mclk_i), .resetn_i(resetn_i),
		.take_i(take), .word_o(word));

	initial begin
		mclk_i = 1'b0;
		forever #4 mclk_i = ~mclk_i;
	end

	// hang guard: the whole run needs well under a thousand clocks
	always @(posedge mclk_i) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			error_cnt++;
			tally_and_finish();
		end
	end

	task automatic chk(input logic [19:0] got, input logic [19:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic start(input logic [15:0] p[12]);
		resetn_i <= 1'b0;
		repeat (3) @(posedge mclk_i);
		for (int i = 0; i < 16; i++)
			mcuid_pmem_i.mem[i] = (i < 12) ? p[i] : 16'h0000;
		resetn_i <= 1'b1;
	endtask

	// waits for the next cycle start, then judges op and take
	task automatic ins(input mcuid_op_t op, input logic tk);
		int n;
		n = 0;
		do begin
			@(posedge mclk_i);
			#1;
			n++;
		end while (phase !== 2'h0 && n < 8);
		chk(ctrl.op, op);
		chk(take, tk);
	endtask

	task automatic wr(input logic [1:0] a, input logic [15:0] d);
		@(posedge mclk_i);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge mclk_i);
		wr_s <= 1'b0;
	endtask

	task automatic rd(input logic [1:0] a, input logic [15:0] exp);
		@(posedge mclk_i);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge mclk_i);
		rd_s <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask

	task automatic t_regs;
		start('{default: 16'h0000});
		rd(REG_STATUS, 16'h000C);
		wr(REG_STATUS, 16'h001F);
		rd(REG_STATUS, 16'h000C);
		wr(REG_BANK, 16'h00A7);
		rd(REG_BANK, 16'h0007);
		chk(bank, 8'h07);
		rd(REG_CTRL, 16'h0001);
		// a stopped core takes no further words
		wr(REG_CTRL, 16'h0000);
		ins(OP_NOP, 1'b0);
		rd(REG_CTRL, 16'h0000);
		rd(REG_WORD, 16'h0000);
		$display("t_regs done");
	endtask

	task automatic t_byte;
		presc <= 1'b1;
		start('{16'h0103, 16'h2312, 16'h2180, 16'h2280, 16'h9A34, 16'h6AD6,
			16'h0EAB, 16'h0DFF, 16'h6212, 16'h0C55, 16'h0000, 16'h0000});
		ins(OP_BANKLIT, 1'b1);
		chk(ctrl.flag_mask, FM_NONE);
		ins(OP_BYTE, 1'b1);
		chk(bank, 8'h03);
		chk(ctrl.dest_file, 1'b1);
		chk(ctrl.file_addr, 12'h312);
		chk(ctrl.flag_mask, FM_ALL);
		ins(OP_BYTE, 1'b1);
		chk(ctrl.dest_file, 1'b0);
		chk(ctrl.file_addr, 12'h380);
		ins(OP_BYTE, 1'b1);
		chk(ctrl.file_addr, 12'hF80);
		chk(ctrl.use_pins, 1'b1);
		ins(OP_BIT, 1'b1);
		chk(ctrl.bit_pos, 3'h5);
		chk(ctrl.file_addr, 12'h034);
		ins(OP_BYTE, 1'b1);
		chk(ctrl.clr_prescaler, 1'b1);
		ins(OP_LIT, 1'b1);
		chk(ctrl.literal, 8'hAB);
		ins(OP_MULLIT, 1'b1);
		chk(ctrl.flag_mask, FM_NONE);
		ins(OP_BYTE, 1'b1);
		@(posedge mclk_i);
		skip <= 1'b1;
		ins(OP_NOP, 1'b1);
		@(posedge mclk_i);
		skip <= 1'b0;
		// only one nop cycle: the word after the dropped one runs at once
		ins(OP_NOP, 1'b1);
		$display("t_byte done");
	endtask

	task automatic t_branch;
		logic [7:0] hit;
		hit = 8'h96;
		flags <= 5'b10010;
		start('{16'hE010, 16'hE110, 16'hE210, 16'hE310, 16'hE410, 16'hE510,
			16'hE610, 16'hE710, 16'hD7FF, 16'hC123, 16'hF456, 16'hF789});
		for (int i = 0; i < 8; i++) begin
			ins(OP_BRA_COND, 1'b1);
			chk(ctrl.branch_taken, hit[i]);
			if (hit[i])
				ins(OP_NOP, 1'b0);
		end
		ins(OP_BRA_REL, 1'b1);
		chk(ctrl.rel_offset, 11'h7FF);
		ins(OP_NOP, 1'b0);
		ins(OP_NOP, 1'b1);
		ins(OP_MOVE_FF, 1'b1);
		chk(ctrl.file_addr, 12'h123);
		chk(ctrl.dst_addr, 12'h456);
		ins(OP_NOP, 1'b1);
		$display("t_branch done");
	endtask

	task automatic t_ctrl;
		busy <= 1'b1;
		start('{16'h0011, 16'h0003, 16'h000B, 16'h0004, 16'h000D, 16'h0C55,
			16'hEC12, 16'hF345, 16'h0002, 16'h0013, 16'hEF55, 16'hF123});
		ins(OP_INTERRUPT_RETURN, 1'b1);
		chk(ctrl.fast, 1'b1);
		chk(ctrl.irq_enable_set, 1'b1);
		ins(OP_NOP, 1'b0);
		ins(OP_SLEEP, 1'b1);
		ins(OP_TBL_RD, 1'b1);
		chk(pd_f, 1'b0);
		chk(to_f, 1'b1);
		chk(ctrl.tbl_mode, 2'h3);
		chk(step, 1'b1);
		ins(OP_NOP, 1'b0);
		ins(OP_CLRWDT, 1'b1);
		ins(OP_TBL_WR, 1'b1);
		chk(pd_f, 1'b1);
		chk(ctrl.tbl_mode, 2'h1);
		repeat (3) begin
			ins(OP_NOP, 1'b0);
			chk(tbl_act, 1'b1);
		end
		@(posedge mclk_i);
		busy <= 1'b0;
		// the cycle that ends the stall is one more nop
		ins(OP_NOP, 1'b0);
		chk(tbl_act, 1'b0);
		ins(OP_LITERAL_RETURN, 1'b1);
		chk(ctrl.literal, 8'h55);
		chk(ctrl.working_register_load, 1'b1);
		ins(OP_NOP, 1'b0);
		ins(OP_NOP, 1'b1);
		ins(OP_CALL, 1'b1);
		chk(ctrl.target, 20'h34512);
		chk(ctrl.fast, 1'b0);
		ins(OP_NOP, 1'b1);
		ins(OP_RETURN, 1'b1);
		chk(ctrl.fast, 1'b1);
		ins(OP_NOP, 1'b0);
		ins(OP_NOP, 1'b1);
		ins(OP_GOTO, 1'b1);
		chk(ctrl.target, 20'h12355);
		$display("t_ctrl done");
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		resetn_i = 1'b0;
		flags = 5'h00;
		skip = 1'b0;
		presc = 1'b0;
		busy = 1'b0;
		addr = 2'h0;
		wdata = 16'h0000;
		wr_s = 1'b0;
		rd_s = 1'b0;
		error_cnt = 0;
		checks_done = 0;
		cycles = 0;
		t_regs();
		t_byte();
		t_branch();
		t_ctrl();
		tally_and_finish();
	end
endmodule
